// ### design/irc_top.sv
// Interrupt control and reset-cause status logic
`timescale 1ns/100ps
`include "irc_defines.svh"
// Notes on behaviour
// - Reset from power-on, reset pin pulse or watchdog; power-on sets both flags.
// - Pin reset while running keeps time-out and power-down flags.
// - Pin reset waking from sleep: time-out 1, power-down 0.
// - Watchdog reset while running: time-out 0, power-down kept.
// - Watchdog reset waking from sleep: both flags 0.
// - Port change wake-up: time-out 1, power-down 0.
// - Watchdog clear sets both; time-out clears time-out; sleep sets 1,0.
// - Three sources: falling edges of timer overflow and external pin, and any port change.
// - Port change ignores output pins and bit 0 when used as external input.
// - Port change wakes sleep only if enabled before sleep began.
// - After change wake-up: continue sequentially, or vector 008H if enabled.
// - Flag register holds each request; mask register gates each source.
// - Enable instruction sets global enable; disable instruction clears it.
// - Enabled interrupt fetches next instruction from 008H.
// - All flags but port change set regardless of mask and global enable.
// - Reading the flag register returns flags AND mask.
// - Return-from-interrupt ends service and sets global enable.
// - Software trap with interrupts enabled fetches from 001H.
module irc_top
	import irc_pkg::*;
#(
	parameter int PORT_W = 8,
	parameter int PC_W   = 10
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              por,
	input  wire logic              reset_pin_pulse,
	input  wire logic              watchdog_timeout,
	input  wire logic              watchdog_clear_instr,
	input  wire logic              sleep_instr,
	input  wire logic              global_int_enable_instr,
	input  wire logic              global_int_disable_instr,
	input  wire logic              return_from_interrupt_instr,
	input  wire logic              soft_trap_instr,
	input  wire logic              timer_counter_overflow,
	input  wire logic [PORT_W-1:0] port6_in,
	input  wire logic [PORT_W-1:0] port6_is_output,
	input  wire logic              ext_int_select,
	input  wire logic              port6_read,
	input  wire logic [PC_W-1:0]   next_pc,
	input  wire logic [3:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	output logic                   core_reset_ff,
	output logic                   sleeping_ff,
	output logic                   vector_load_ff,
	output logic      [PC_W-1:0]   vector_addr_ff,
	output logic                   stack_push_ff,
	output logic      [PC_W-1:0]   stack_data_ff,
	output logic                   time_out_flag_ff,
	output logic                   power_down_flag_ff,
	output logic                   global_enable_ff
);
	// ============================================================
	// Elaboration check
	if (PORT_W < 2 || PC_W < 4) begin : g_chk
		$error("irc_top: PORT_W must be at least 2 and PC_W at least 4");
	end

	// ============================================================
	// State
	// Flags and mask share one layout: timer, change, external
	irc_state_t        state_ff;
	logic [2:0]        flags_ff;
	logic [2:0]        mask_ff;
	logic [PORT_W-1:0] port_ref_ff;
	logic              ext_prev_ff;
	logic              tmr_prev_ff;
	logic              chg_armed_ff;
	logic [2:0]        nxt_flag_set;
	logic              chg_event;
	logic              ext_fall;
	logic              tmr_fall;
	logic              int_take;
	logic              wake_chg;
	logic [PORT_W-1:0] chg_mask;
	logic [PORT_W-1:0] diff_bits;
	logic              flags_wr;
	logic              mask_wr;
	logic              ctrl_wr;
	logic              sleeping;
	logic              nxt_sleep;

	// Sleep state as a plain level for the logic below
	assign sleeping = (state_ff == IRC_SLEEP);

	// ============================================================
	// Change detection
	// Pins eligible for change detection; an output pin would only see
	// its own drive, and bit 0 has its own edge path when selected
	// as the external interrupt input
	genvar gi;
	generate
		for (gi = 0; gi < PORT_W; gi++) begin : g_chg
			if (gi == 0) begin : g_b0
				assign chg_mask[gi] = ~port6_is_output[gi] & ~ext_int_select;
			end else begin : g_bn
				assign chg_mask[gi] = ~port6_is_output[gi];
			end
			assign diff_bits[gi] = chg_mask[gi] & (port6_in[gi] ^ port_ref_ff[gi]);
		end
	endgenerate

	// ============================================================
	// Event detection
	// Falling-edge detection on the timer and external sources; each event lasts one
	// cycle, so a line held low never sets its flag twice
	// The change event is any eligible pin differing from the reference
	assign tmr_fall  = tmr_prev_ff & ~timer_counter_overflow;
	assign ext_fall  = ext_int_select & ext_prev_ff & ~port6_in[0];
	assign chg_event = |diff_bits;
	// Change flag only when its mask is set; others ignore mask
	assign nxt_flag_set[`IRC_BIT_TMR] = tmr_fall;
	assign nxt_flag_set[`IRC_BIT_EXT] = ext_fall;
	assign nxt_flag_set[`IRC_BIT_CHG] = chg_event & mask_ff[`IRC_BIT_CHG];
	// Wake only if armed before sleep
	// The wake path reads the armed copy, not the live mask
	assign wake_chg = sleeping & chg_event & chg_armed_ff;
	// Entry waits until the core is awake and out of reset
	assign int_take = global_enable_ff & |(flags_ff & mask_ff) & ~sleeping
		& ~core_reset_ff;

	// ============================================================
	// Register write decode
	// Writes to unmapped addresses decode to nothing and are dropped
	// A flags write is ORed with same-cycle events further down
	assign flags_wr = reg_wr & (reg_addr == `IRC_ADDR_FLAGS);
	assign mask_wr  = reg_wr & (reg_addr == `IRC_ADDR_MASK);
	assign ctrl_wr  = reg_wr & (reg_addr == `IRC_ADDR_CTRL);

	// ============================================================
	// Edge history
	// Timer history starts low, so a low line after reset is no edge
	// External history starts high, the idle level of the pin
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tmr_prev_ff <= 1'b0;
			ext_prev_ff <= 1'b1;
		end else begin
			tmr_prev_ff <= timer_counter_overflow;
			ext_prev_ff <= port6_in[0];
		end
	end

	// Port reference, refreshed by a port read
	// It also follows each detected change, so one change counts once
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			port_ref_ff <= '0;
		end else if (port6_read || chg_event) begin
			port_ref_ff <= port6_in;
		end
	end

	// ============================================================
	// Interrupt flags and mask
	// Interrupt flags: event set wins over software clear
	// Any reset cause clears them, so no request outlives a reset
	always_ff @(posedge clk_sys) begin
		if (rst || por || reset_pin_pulse || watchdog_timeout) begin
			flags_ff <= 3'h0;
		end else if (flags_wr) begin
			flags_ff <= reg_wdata[2:0] | nxt_flag_set;
		end else begin
			flags_ff <= flags_ff | nxt_flag_set;
		end
	end

	// Mask register
	always_ff @(posedge clk_sys) begin
		if (rst || por || reset_pin_pulse || watchdog_timeout) begin
			mask_ff <= `IRC_MASK_RST;
		end else if (mask_wr) begin
			mask_ff <= reg_wdata[2:0];
		end
	end

	// ============================================================
	// Sleep control
	// Arm change wake-up when the sleep instruction enters sleep
	// The mask is sampled at entry; enabling it later cannot wake
	// Running disarms, so a stale arm cannot wake a later sleep
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			chg_armed_ff <= 1'b0;
		end else if (sleep_instr && !sleeping) begin
			chg_armed_ff <= mask_ff[`IRC_BIT_CHG];
		end else if (!sleeping) begin
			chg_armed_ff <= 1'b0;
		end
	end

	// Next run state, shared by the state register and its output copy
	always_comb begin
		nxt_sleep = sleeping;
		if (por || reset_pin_pulse || watchdog_timeout || wake_chg) begin
			nxt_sleep = 1'b0;
		end else if (sleep_instr || (ctrl_wr && reg_wdata[`IRC_BIT_SLEEP])) begin
			nxt_sleep = 1'b1;
		end
	end

	// Run and sleep state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff <= IRC_RUN;
		end else if (nxt_sleep) begin
			state_ff <= IRC_SLEEP;
		end else begin
			state_ff <= IRC_RUN;
		end
	end

	// ============================================================
	// Reset and status
	// Core reset pulse on any reset cause
	// Held high through the bench reset so the core starts cleanly
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			core_reset_ff <= 1'b1;
		end else begin
			core_reset_ff <= por | reset_pin_pulse | watchdog_timeout;
		end
	end

	// Sleep output loads the same next state, so it never lags the state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sleeping_ff <= 1'b0;
		end else begin
			sleeping_ff <= nxt_sleep;
		end
	end

	// Time-out and power-down status flags
	// Priority: power-on, pin, watchdog, change wake, clear, sleep
	// Only the sleep state decides between the run and wake columns
	always_ff @(posedge clk_sys) begin
		if (rst || por) begin
			time_out_flag_ff   <= 1'b1;
			power_down_flag_ff <= 1'b1;
		end else if (reset_pin_pulse) begin
			if (sleeping) begin
				time_out_flag_ff   <= 1'b1;
				power_down_flag_ff <= 1'b0;
			end
		end else if (watchdog_timeout) begin
			time_out_flag_ff <= 1'b0;
			if (sleeping) begin
				power_down_flag_ff <= 1'b0;
			end
		end else if (wake_chg) begin
			time_out_flag_ff   <= 1'b1;
			power_down_flag_ff <= 1'b0;
		end else if (watchdog_clear_instr) begin
			time_out_flag_ff   <= 1'b1;
			power_down_flag_ff <= 1'b1;
		end else if (sleep_instr) begin
			time_out_flag_ff   <= 1'b1;
			power_down_flag_ff <= 1'b0;
		end
	end

	// ============================================================
	// Global enable and vectoring
	// Global interrupt enable
	// Entry clears the enable so that a handler cannot be re-entered
	// Disable beats enable when both arrive in one cycle
	always_ff @(posedge clk_sys) begin
		if (rst || por || reset_pin_pulse || watchdog_timeout) begin
			global_enable_ff <= 1'b0;
		end else if (int_take || (soft_trap_instr && global_enable_ff)
			|| (wake_chg && global_enable_ff)) begin
			global_enable_ff <= 1'b0;
		end else if (global_int_disable_instr) begin
			global_enable_ff <= 1'b0;
		end else if (global_int_enable_instr || return_from_interrupt_instr) begin
			global_enable_ff <= 1'b1;
		end else if (ctrl_wr) begin
			global_enable_ff <= reg_wdata[`IRC_BIT_GIE];
		end
	end

	// Vectoring and return-address push
	// A reset cause vectors to address zero and pushes nothing
	// The return address is captured in the cycle the entry is decided
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			vector_load_ff <= 1'b0;
			vector_addr_ff <= '0;
			stack_push_ff  <= 1'b0;
			stack_data_ff  <= '0;
		end else begin
			vector_load_ff <= 1'b0;
			stack_push_ff  <= 1'b0;
			if (por || reset_pin_pulse || watchdog_timeout) begin
				vector_load_ff <= 1'b1;
				vector_addr_ff <= '0;
			end else if (soft_trap_instr && global_enable_ff) begin
				vector_load_ff <= 1'b1;
				vector_addr_ff <= PC_W'(`IRC_VEC_TRAP);
				stack_push_ff  <= 1'b1;
				stack_data_ff  <= next_pc;
			end else if ((wake_chg && global_enable_ff) || int_take) begin
				vector_load_ff <= 1'b1;
				vector_addr_ff <= PC_W'(`IRC_VEC_INT);
				stack_push_ff  <= 1'b1;
				stack_data_ff  <= next_pc;
			end
		end
	end

	// ============================================================
	// Register read port
	// Register read port, data one cycle after strobe
	// Idle cycles return zero, so several ports can be ORed together
	// Status bits sit at their documented positions, others read zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`IRC_ADDR_STATUS: reg_rdata <= {3'h0, time_out_flag_ff,
					power_down_flag_ff, 3'h0};
				`IRC_ADDR_FLAGS:  reg_rdata <= {5'h00, flags_ff & mask_ff};
				`IRC_ADDR_MASK:   reg_rdata <= {5'h00, mask_ff};
				`IRC_ADDR_CTRL:   reg_rdata <= {6'h00, sleeping, global_enable_ff};
				default:          reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule : irc_top

// ### include/irc_defines.svh
// Constants for the interrupt and reset-cause block
`ifndef IRC_DEFINES_SVH
`define IRC_DEFINES_SVH
// ============================================================
// Register addresses
`define IRC_ADDR_STATUS   4'h0
`define IRC_ADDR_FLAGS    4'h1
`define IRC_ADDR_MASK     4'h2
`define IRC_ADDR_CTRL     4'h3
// ============================================================
// Field positions
`define IRC_BIT_TMR       0
`define IRC_BIT_CHG       1
`define IRC_BIT_EXT       2
`define IRC_BIT_TO        4
`define IRC_BIT_PD        3
`define IRC_BIT_GIE       0
`define IRC_BIT_SLEEP     1
// ============================================================
// Reset values and vectors
`define IRC_MASK_RST      3'h0
`define IRC_VEC_INT       10'h008
`define IRC_VEC_TRAP      10'h001
`endif

// ### include/irc_pkg.sv
// Types for the interrupt and reset-cause block
package irc_pkg;
	// ============================================================
	// Core run state
	typedef enum logic [0:0] {
		IRC_RUN,
		IRC_SLEEP
	} irc_state_t;
	// Cause of a reset
	typedef enum logic [1:0] {
		IRC_RC_NONE,
		IRC_RC_PIN,
		IRC_RC_WDOG
	} irc_cause_t;
endpackage : irc_pkg

// ### verification/irc_chk.sv
// Assertions on the ports of the interrupt and reset-cause block
`timescale 1ns/100ps
`include "irc_defines.svh"
module irc_chk #(
	parameter int PC_W = 10
) (
	input wire logic            clk_sys,
	input wire logic            rst,
	input wire logic            por,
	input wire logic            reset_pin_pulse,
	input wire logic            watchdog_timeout,
	input wire logic            watchdog_clear_instr,
	input wire logic            sleep_instr,
	input wire logic            global_int_enable_instr,
	input wire logic            global_int_disable_instr,
	input wire logic            return_from_interrupt_instr,
	input wire logic            reg_rd,
	input wire logic [7:0]      reg_rdata,
	input wire logic            core_reset_ff,
	input wire logic            sleeping_ff,
	input wire logic            vector_load_ff,
	input wire logic [PC_W-1:0] vector_addr_ff,
	input wire logic            stack_push_ff,
	input wire logic            time_out_flag_ff,
	input wire logic            power_down_flag_ff,
	input wire logic            global_enable_ff
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ============================================================
	// Reset causes
	sequence s_pin;
		reset_pin_pulse && !por;
	endsequence
	sequence s_wdog;
		watchdog_timeout && !por && !reset_pin_pulse;
	endsequence
	sequence s_quiet;
		!por && !reset_pin_pulse && !watchdog_timeout && !sleeping_ff;
	endsequence
	// ============================================================
	// Status flags
	a_por_flags: assert property (
		por |=> core_reset_ff && time_out_flag_ff && power_down_flag_ff)
		else $error("power-on flags wrong");
	a_pin_keep: assert property (
		s_pin ##0 !sleeping_ff |=> $stable(time_out_flag_ff) && $stable(power_down_flag_ff))
		else $error("pin reset changed flags");
	a_pin_wake: assert property (
		s_pin ##0 sleeping_ff |=> time_out_flag_ff && !power_down_flag_ff)
		else $error("pin wake flags wrong");
	a_wdog_run: assert property (
		s_wdog ##0 !sleeping_ff |=> !time_out_flag_ff && $stable(power_down_flag_ff))
		else $error("watchdog run flags wrong");
	a_wdog_wake: assert property (
		s_wdog ##0 sleeping_ff |=> !time_out_flag_ff && !power_down_flag_ff)
		else $error("watchdog wake flags wrong");
	a_watchdog_clear_instr_sets: assert property (
		s_quiet ##0 watchdog_clear_instr |=> time_out_flag_ff && power_down_flag_ff)
		else $error("clear flags wrong");
	a_sleep_flags: assert property (
		s_quiet ##0 sleep_instr && !watchdog_clear_instr
		|=> time_out_flag_ff && !power_down_flag_ff)
		else $error("sleep flags wrong");
	// ============================================================
	// Global enable, entry and read port
	a_gie_on: assert property (
		(global_int_enable_instr || return_from_interrupt_instr) && !global_int_disable_instr
		&& !global_enable_ff && !por && !reset_pin_pulse && !watchdog_timeout
		|=> global_enable_ff)
		else $error("global enable not set");
	a_gie_off: assert property (
		global_int_disable_instr && !global_int_enable_instr
		&& !return_from_interrupt_instr |=> !global_enable_ff)
		else $error("global enable not cleared");
	a_entry_push: assert property (
		vector_load_ff && vector_addr_ff != '0 |-> stack_push_ff && !global_enable_ff)
		else $error("entry without push");
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
endmodule : irc_chk
bind irc_top irc_chk #(.PC_W(PC_W)) u_chk (.*);

// ### verification/irc_pin_model.sv
// Model of the external timer and interrupt pins
`timescale 1ns/100ps
module irc_pin_model (
	input  wire logic clk_sys,
	input  wire logic tmr_go,
	input  wire logic ext_go,
	output logic      timer_counter_overflow,
	output logic      ext_pin
);
	// ============================================================
	// Pins idle high; one low cycle per request gives one falling edge
	always_ff @(posedge clk_sys) begin
		timer_counter_overflow <= !tmr_go;
		ext_pin                <= !ext_go;
	end
endmodule : irc_pin_model

// ### verification/test_irc_top.sv
// Self-checking testbench for the interrupt and reset-cause block
`timescale 1ns/100ps
`include "irc_defines.svh"
module test_irc_top;
	logic       clk_sys, rst, reg_wr, reg_rd, timer_counter_overflow, xp, tg, xg;
	logic       core_reset_ff, sleeping_ff, vector_load_ff, stack_push_ff;
	logic       time_out_flag_ff, power_down_flag_ff, global_enable_ff;
	logic [4:0] e, i;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, p6;
	logic [9:0] next_pc, vector_addr_ff, stack_data_ff;
	int         err_count = 0, n_tests = 0, t = 1, p = 1, g, s, m, f, n;
	int         q[] = '{3, 2, 1, 4, 1, 4, 2, 2, 1, 0};
	irc_top dut (.*, .por(e[0]), .reset_pin_pulse(e[1]), .watchdog_timeout(e[2]),
		.watchdog_clear_instr(e[3]), .sleep_instr(e[4]), .global_int_enable_instr(i[0]),
		.global_int_disable_instr(i[1]), .return_from_interrupt_instr(i[2]),
		.soft_trap_instr(i[3]), .port6_read(i[4]), .port6_in({p6[7:1], xp}),
		.port6_is_output(8'h40), .ext_int_select(1'b1));
	irc_pin_model pins (.clk_sys(clk_sys), .tmr_go(tg), .ext_go(xg),
		.timer_counter_overflow(timer_counter_overflow), .ext_pin(xp));
	// ============================================================
	// Clock
	initial begin
		clk_sys = 0;
		forever #4 clk_sys = ~clk_sys;
	end
	// ============================================================
	// Tasks, each entered just after a rising edge
	task automatic chk(logic [9:0] seen, logic [9:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic look();
		@(negedge clk_sys);
		chk(time_out_flag_ff, 10'(t));
		chk(power_down_flag_ff, 10'(p));
		chk(sleeping_ff, 10'(s));
		@(posedge clk_sys);
	endtask : look
	task automatic ev(int k);
		e <= 5'(1 << k);
		@(posedge clk_sys);
		e <= '0;
		case (k)
			0, 3: begin t = 1; p = 1; end
			1: if (s) begin t = 1; p = 0; end
			2: begin t = 0; if (s) p = 0; end
			default: begin t = 1; p = 0; end
		endcase
		if (k < 3) begin g = 0; m = 0; f = 0; end
		s = (k == 4);
		repeat (2) @(posedge clk_sys);
		look();
	endtask : ev
	task automatic wr(logic [3:0] a, logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk_sys);
		reg_wr <= 0;
	endtask : wr
	task automatic rd(logic [3:0] a, int x);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk_sys);
		reg_rd <= 0;
		@(negedge clk_sys);
		chk(reg_rdata, 10'(x));
		@(posedge clk_sys);
	endtask : rd
	task automatic vec(int a);
		n = 0;
		#1;
		while (vector_load_ff !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk(vector_addr_ff, 10'(a));
		chk(stack_data_ff, next_pc);
		chk({stack_push_ff, global_enable_ff}, 10'h2);
		g = 0;
		@(posedge clk_sys);
	endtask : vec
	task automatic ins(int k);
		i <= 5'(1 << k);
		@(posedge clk_sys);
		i <= '0;
		if (k == 3) begin
			vec(`IRC_VEC_TRAP);
		end else begin
			if (k == 0 || k == 2) g = 1;
			if (k == 1) g = 0;
			@(negedge clk_sys);
			chk(global_enable_ff, 10'(g));
			@(posedge clk_sys);
		end
	endtask : ins
	task automatic pin(int k);
		{xg, tg} <= 2'(1 << k);
		@(posedge clk_sys);
		{xg, tg} <= '0;
	endtask : pin
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	// ============================================================
	// Main sequence
	initial begin
		void'($urandom(8200));
		{rst, reg_wr, reg_rd, tg, xg, e, i, reg_addr, reg_wdata} = 27'h4000000;
		p6 = 8'($urandom);
		next_pc = 10'($urandom);
		repeat (12) @(posedge clk_sys);
		rst <= 0;
		@(posedge clk_sys);
		look();
		rd(`IRC_ADDR_STATUS, 8'h18);
		rd(4'h9, 0);
		pin(0);
		f = 1;
		rd(`IRC_ADDR_FLAGS, 0);
		m = ($urandom & 7) | 1;
		wr(`IRC_ADDR_MASK, 8'(m));
		rd(`IRC_ADDR_MASK, m);
		rd(`IRC_ADDR_FLAGS, f & m);
		wr(`IRC_ADDR_FLAGS, 8'h00);
		ins(0);
		pin(0);
		vec(`IRC_VEC_INT);
		rd(`IRC_ADDR_FLAGS, 1);
		wr(`IRC_ADDR_FLAGS, 8'h00);
		ins(2);
		ins(3);
		ins(2);
		ins(1);
		// External pin edge is not a port change; output pin is ignored
		pin(1);
		wr(`IRC_ADDR_MASK, 8'h06);
		ins(4);
		ev(4);
		p6 <= p6 ^ 8'h40;
		repeat (3) @(posedge clk_sys);
		look();
		p6 <= p6 ^ 8'h08;
		s = 0;
		repeat (3) @(posedge clk_sys);
		look();
		rd(`IRC_ADDR_FLAGS, 6);
		foreach (q[j]) ev(q[j]);
		// Change wake with global enable vectors
		wr(`IRC_ADDR_MASK, 8'h02);
		ins(4);
		ins(0);
		ev(4);
		p6 <= p6 ^ 8'h10;
		@(posedge clk_sys);
		vec(`IRC_VEC_INT);
		finish_test();
	end
	// ============================================================
	// Watchdog against a hang
	initial begin
		#20000;
		err_count++;
		finish_test();
	end
endmodule : test_irc_top
